// File: logic/spc_pkg.sv
// constants for the serial port control and transmit status slice
package spc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
    localparam logic [4:0] OFF_CTRL_TWO = 5'h04;
    localparam logic [4:0] OFF_STATUS_ONE = 5'h08;
    localparam logic [4:0] OFF_DATA = 5'h0c;
    localparam logic [4:0] OFF_CTRL_AUX = 5'h10;
    // ----------------------------------------------------------------
    // ctrl_reg_two fields
    // ----------------------------------------------------------------
    localparam int B_EMPTY_IRQ_EN = 7;
    localparam int B_DONE_IRQ_EN = 6;
    localparam int B_FULL_IRQ_EN = 5;
    localparam int B_QUIET_IRQ_EN = 4;
    localparam int B_XMIT_SWITCH = 3;
    localparam int B_RX_ON = 2;
    localparam int B_RX_SLEEP = 1;
    localparam int B_BREAK_SEND = 0;
    // ----------------------------------------------------------------
    // ctrl_one, aux and status fields
    // ----------------------------------------------------------------
    localparam int B_LOOPBACK = 7;
    localparam int B_RX_INPUT_CHOICE = 5;
    localparam int B_WAKE_METHOD = 3;
    localparam int B_LINE_DIR = 1;
    localparam int B_LONG_BREAK = 0;
    localparam int B_TX_BUF_EMPTY = 7;
    localparam int B_TX_DONE = 6;
    localparam int B_RX_BUF_FULL = 5;
    localparam int B_LINE_QUIET = 4;
    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [15:0] BIT_CYCLES = 16'h0010;
    localparam logic [15:0] HALF_BIT_CYCLES = BIT_CYCLES >> 1;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] BREAK_BITS = 4'ha;
    localparam logic [3:0] LONG_BREAK_BITS = 4'hd;
    localparam logic [19:0] IDLE_CYCLES = 20'(BIT_CYCLES * 10);

    typedef enum logic [1:0] {TX_FREE, TX_BUSY} spc_tx_type;
    typedef enum logic [1:0] {RX_WAIT, RX_START, RX_BITS} spc_rx_type;
endpackage : spc_pkg

// File: logic/spc_serial_port.sv
// serial port control, transmit status, minimal shifter and receiver
// ----------------------------------------------------------------
// Overview of operation
// - empty_irq_en set: tx_buf_empty raises interrupt request
// - done_irq_en set: tx_done_flag raises interrupt request
// - full_irq_en set: rx_buf_full raises interrupt request
// - line_quiet_irq_en set: idle-line flag raises interrupt request
// - transmitter starts frames from idle only with xmit_switch set; port owns output pin
// - single-wire mode: single_line_direction sets output pin direction
// - xmit_switch 0 then 1 queues one idle character
// - after xmit_switch cleared, pin kept until pending traffic ends
// - input pin released when rx_on clear or loopback_select set
// - rx_sleep_request puts receiver in standby until wake condition
// - wake condition clears rx_sleep_request in hardware
// - break_send_ctl 1 then 0 queues one break character
// - break_send_ctl held 1 keeps queuing breaks of 10 or 13 bits
// - a second break may be queued before software clears the bit
// - control register two readable and writable at any time
// - status register read only; flags cleared by read sequences
// - tx_buf_empty set at reset and on buffer-to-shifter transfer
// - tx_buf_empty cleared by status read then data write
// - tx_done_flag set at reset and when empty and shifter idle
// - rx_buf_full set when received character reaches data register
// - idle-line flag set after one quiet character time following activity
// - single-wire mode joins output pin to transmitter and receiver
// ----------------------------------------------------------------
`timescale 1ns/10ps
module spc_serial_port
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic serial_out_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe,
    input wire logic serial_in_pin,
    output logic serial_in_pin_owned,
    output logic irq
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rst_pipe <= 2'h0;
        else rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // stage one feeds only stage two; a change counts when 2 and 3 agree
    logic [1:0] sync_a, sync_b, sync_c, pin_f;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 2'h3;
            sync_b <= 2'h3;
            sync_c <= 2'h3;
            pin_f <= 2'h3;
        end else begin
            sync_a <= {serial_out_pin_in, serial_in_pin};
            sync_b <= sync_a;
            sync_c <= sync_b;
            for (int i = 0; i < 2; i++) begin
                if (sync_b[i] == sync_c[i]) pin_f[i] <= sync_c[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // registers and bus decode
    // ----------------------------------------------------------------
    logic [7:0] ctrl_one, ctrl_two, ctrl_aux, tx_buf, rx_data;
    logic wait_q;
    logic tx_buf_empty, tx_done_flag, rx_buf_full, line_quiet;
    logic empty_armed, done_armed, full_armed, quiet_armed;
    wire wr_acc = write & ~wait_q;
    wire rd_acc = read & ~wait_q;
    wire wr_one = wr_acc & (address == OFF_CTRL_ONE);
    wire wr_two = wr_acc & (address == OFF_CTRL_TWO);
    wire wr_aux = wr_acc & (address == OFF_CTRL_AUX);
    wire wr_data = wr_acc & (address == OFF_DATA);
    wire rd_stat = rd_acc & (address == OFF_STATUS_ONE);
    wire rd_data = rd_acc & (address == OFF_DATA);
    wire [7:0] wd = writedata[7:0];
    wire [7:0] status_one = {tx_buf_empty, tx_done_flag, rx_buf_full,
        line_quiet, 4'h0};
    wire xmit_switch = ctrl_two[B_XMIT_SWITCH];
    wire rx_on = ctrl_two[B_RX_ON];
    wire break_send_ctl = ctrl_two[B_BREAK_SEND];
    wire loopback_select = ctrl_one[B_LOOPBACK];
    wire rx_input_choice = ctrl_one[B_RX_INPUT_CHOICE];
    wire single_wire = loopback_select & rx_input_choice;
    wire wake_method = ctrl_one[B_WAKE_METHOD];

    function automatic logic [7:0] pick(input logic [4:0] a,
        input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] st,
        input logic [7:0] dt, input logic [7:0] ax);
        case (a)
            OFF_CTRL_ONE: pick = c1;
            OFF_CTRL_TWO: pick = c2;
            OFF_STATUS_ONE: pick = st;
            OFF_DATA: pick = dt;
            OFF_CTRL_AUX: pick = ax;
            default: pick = 8'h00;
        endcase
    endfunction : pick

    wire [7:0] rd_mux = pick(address, ctrl_one, ctrl_two, status_one,
        rx_data, ctrl_aux);

    // one wait state: request seen, answer on the following edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            readdata <= 32'h0;
        end else begin
            wait_q <= ~((read | write) & wait_q);
            if (read & wait_q) readdata <= {24'h0, rd_mux};
        end
    end
    assign waitrequest = wait_q;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic wake_clear, idle_queue_req, break_queue_req;
    // queue idle on 0 to 1
    wire te_rise = wr_two & wd[B_XMIT_SWITCH] & ~xmit_switch;
    wire sbk_fall = wr_two & ~wd[B_BREAK_SEND] & break_send_ctl;
    wire sbk_set = wr_two & wd[B_BREAK_SEND];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one <= RST_CTRL;
            ctrl_two <= RST_CTRL;
            ctrl_aux <= RST_CTRL;
        end else begin
            if (wr_one) ctrl_one <= wd;
            if (wr_aux) ctrl_aux <= wd & 8'h03;
            if (wr_two) ctrl_two <= wd;
            else if (wake_clear) ctrl_two[B_RX_SLEEP] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    spc_tx_type tx_state;
    logic [12:0] tx_shift;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    logic idle_pending, break_pending, tx_line;
    wire buf_loaded = ~tx_buf_empty;
    wire tx_busy = (tx_state == TX_BUSY);
    wire [3:0] brk_len = ctrl_aux[B_LONG_BREAK] ? LONG_BREAK_BITS : BREAK_BITS;
    wire bit_end = tx_busy & (tx_cnt == BIT_CYCLES - 16'h1);
    wire frame_end = bit_end & (tx_left == 4'h1);
    // fresh frames only while enabled; a running chain drains
    wire shifter_free = (~tx_busy & xmit_switch) | frame_end;
    wire break_go = shifter_free & (break_pending | break_send_ctl);
    wire idle_go = shifter_free & ~break_go & idle_pending;
    // new data only while enabled, buffered data still drains
    wire data_go = shifter_free & ~break_go & ~idle_pending & buf_loaded;
    wire tx_start = break_go | idle_go | data_go;
    assign idle_queue_req = te_rise;
    assign break_queue_req = sbk_fall;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_FREE;
            tx_shift <= 13'h1fff;
            tx_left <= 4'h0;
            tx_cnt <= 16'h0;
        end else if (tx_start) begin
            tx_state <= TX_BUSY;
            tx_cnt <= 16'h0;
            if (break_go) begin
                tx_shift <= 13'h0;
                tx_left <= brk_len;
            end else if (idle_go) begin
                tx_shift <= 13'h1fff;
                tx_left <= FRAME_BITS;
            end else begin
                tx_shift <= {4'hf, tx_buf, 1'b0};
                tx_left <= FRAME_BITS;
            end
        end else if (frame_end) begin
            tx_state <= TX_FREE;
            tx_shift <= 13'h1fff;
        end else if (bit_end) begin
            tx_cnt <= 16'h0;
            tx_shift <= {1'b1, tx_shift[12:1]};
            tx_left <= tx_left - 4'h1;
        end else if (tx_busy) begin
            tx_cnt <= tx_cnt + 16'h1;
        end
    end
    assign tx_line = tx_busy ? tx_shift[0] : 1'b1;

    // request arriving while a break starts stays queued
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_pending <= 1'b0;
            break_pending <= 1'b0;
        end else begin
            if (idle_queue_req) idle_pending <= 1'b1;
            else if (idle_go) idle_pending <= 1'b0;
            if (break_queue_req) break_pending <= 1'b1;
            else if (break_go) break_pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // transmit status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf <= RST_DATA;
            tx_buf_empty <= 1'b1;
            tx_done_flag <= 1'b1;
            empty_armed <= 1'b0;
            done_armed <= 1'b0;
        end else begin
            if (rd_stat) empty_armed <= tx_buf_empty;
            if (rd_stat) done_armed <= tx_done_flag;
            if (wr_data) tx_buf <= wd;
            // transfer frees the buffer; set wins over clear
            if (data_go) tx_buf_empty <= 1'b1;
            else if (wr_data & empty_armed & tx_buf_empty) begin
                tx_buf_empty <= 1'b0;
                empty_armed <= 1'b0;
            end
            // empty and nothing on the line
            if (tx_buf_empty & ~tx_busy & ~idle_pending & ~break_pending
                & ~break_send_ctl & ~(wr_data & empty_armed)
                & ~te_rise & ~sbk_set)
                tx_done_flag <= 1'b1;
            else if (done_armed & (wr_data | te_rise | sbk_set)) begin
                tx_done_flag <= 1'b0;
                done_armed <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // receiver input selection
    // ----------------------------------------------------------------
    // single wire reads the output pin, internal loop reads tx
    wire rx_line = ~loopback_select ? pin_f[0] :
        (rx_input_choice ? pin_f[1] : tx_line);

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    spc_rx_type rx_state;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic [19:0] quiet_cnt;
    logic rx_active;
    wire rx_sleep = ctrl_two[B_RX_SLEEP];
    wire rx_sample = (rx_state == RX_BITS) & (rx_cnt == BIT_CYCLES - 16'h1);
    wire rx_done = rx_sample & (rx_bits == FRAME_BITS - 4'h2);
    wire [7:0] rx_byte = rx_shift[8:1];
    wire quiet_hit = rx_active & (quiet_cnt == IDLE_CYCLES - 20'h1);
    // standby blocks delivery; wake by mark bit or quiet line
    wire wake_by_mark = rx_done & rx_sleep & wake_method & rx_shift[8];
    wire wake_by_quiet = quiet_hit & rx_sleep & ~wake_method;
    wire deliver = rx_done & (~rx_sleep | wake_by_mark);
    assign wake_clear = wake_by_mark | wake_by_quiet;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_WAIT;
            rx_cnt <= 16'h0;
            rx_bits <= 4'h0;
            rx_shift <= 9'h0;
        end else if (!rx_on) begin
            rx_state <= RX_WAIT;
        end else begin
            case (rx_state)
                RX_WAIT: begin
                    rx_cnt <= 16'h0;
                    if (!rx_line) rx_state <= RX_START;
                end
                RX_START: begin
                    rx_cnt <= rx_cnt + 16'h1;
                    if (rx_line) rx_state <= RX_WAIT;
                    else if (rx_cnt == HALF_BIT_CYCLES - 16'h1) begin
                        rx_state <= RX_BITS;
                        rx_cnt <= 16'h0;
                        rx_bits <= 4'h0;
                    end
                end
                RX_BITS: begin
                    rx_cnt <= rx_cnt + 16'h1;
                    if (rx_sample) begin
                        rx_cnt <= 16'h0;
                        rx_bits <= rx_bits + 4'h1;
                        rx_shift <= {rx_line, rx_shift[8:1]};
                        if (rx_done) rx_state <= RX_WAIT;
                    end
                end
                default: rx_state <= RX_WAIT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= RST_DATA;
            rx_buf_full <= 1'b0;
            line_quiet <= 1'b0;
            full_armed <= 1'b0;
            quiet_armed <= 1'b0;
            rx_active <= 1'b0;
            quiet_cnt <= 20'h0;
        end else begin
            if (rd_stat) full_armed <= rx_buf_full;
            if (rd_stat) quiet_armed <= line_quiet;
            if (deliver) rx_data <= rx_byte;
            // character reaches data register; set wins
            if (deliver) rx_buf_full <= 1'b1;
            else if (rd_data & full_armed) begin
                rx_buf_full <= 1'b0;
                full_armed <= 1'b0;
            end
            // one quiet character time after activity, once only
            if (quiet_hit & ~rx_sleep) line_quiet <= 1'b1;
            else if (rd_data & quiet_armed) begin
                line_quiet <= 1'b0;
                quiet_armed <= 1'b0;
            end
            if (!rx_on || !rx_line || rx_state != RX_WAIT)
                quiet_cnt <= 20'h0;
            else if (rx_active) quiet_cnt <= quiet_cnt + 20'h1;
            if (rx_done) rx_active <= 1'b1;
            else if (quiet_hit) rx_active <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pins and interrupt
    // ----------------------------------------------------------------
    // keep pin while xmit_switch is set or a frame is shifting
    wire tx_owned = xmit_switch | tx_busy;
    // direction bit gates the drive in single-wire mode
    wire next_oe = tx_owned & (~single_wire | ctrl_aux[B_LINE_DIR]);
    // input pin released when off or looped
    wire next_in_owned = rx_on & ~loopback_select;
    wire next_irq = (ctrl_two[B_EMPTY_IRQ_EN] & tx_buf_empty)
        | (ctrl_two[B_DONE_IRQ_EN] & tx_done_flag)
        | (ctrl_two[B_FULL_IRQ_EN] & rx_buf_full)
        | (ctrl_two[B_QUIET_IRQ_EN] & line_quiet);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_pin_out <= 1'b1;
            serial_out_pin_oe <= 1'b0;
            serial_in_pin_owned <= 1'b0;
            irq <= 1'b0;
        end else begin
            serial_out_pin_out <= tx_line;
            serial_out_pin_oe <= next_oe;
            serial_in_pin_owned <= next_in_owned;
            irq <= next_irq;
        end
    end
endmodule : spc_serial_port

// File: test/spc_remote_peer.sv
// remote transceiver model on the two serial lines
`timescale 1ns/10ps
module spc_remote_peer (
    input wire logic clk,
    input wire logic tx_line,
    output logic rx_line,
    output logic wire_drive
);
    // idle high on both lines, where the pull-up leaves them
    initial begin
        rx_line = 1'b1;
        wire_drive = 1'b1;
    end
    // start, eight data bits lsb first, stop; 16 clocks a bit
    task automatic send(input logic [7:0] b, input bit on_wire);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            if (on_wire) wire_drive <= f[i];
            else rx_line <= f[i];
            repeat (15) @(posedge clk);
        end
    endtask : send
    // samples mid bit; bounded wait so a silent line cannot hang
    task automatic grab(output logic [7:0] b, output logic stp);
        int k;
        k = 0;
        while (tx_line !== 1'b0 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk);
            b[i] = tx_line;
        end
        repeat (16) @(posedge clk);
        stp = tx_line;
    endtask : grab
endmodule : spc_remote_peer

// File: test/spc_serial_port_monitor.sv
// checker for the bus and line ports of the serial port slice
`timescale 1ns/10ps
module spc_serial_port_monitor
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic serial_out_pin_out,
    input wire logic serial_out_pin_oe,
    input wire logic serial_in_pin_owned,
    input wire logic irq
);
    // ------------------------------------------------------------
    // shadow of the control writes and low run of the line
    // ------------------------------------------------------------
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    logic last_out;
    logic [15:0] run;
    wire logic take = write & ~waitrequest;
    wire logic own_exp = ctl_two[B_RX_ON] & ~ctl_one[B_LOOPBACK];
    // the sleep bit of the shadow goes stale once hardware clears it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_one <= 8'h00;
            ctl_two <= 8'h00;
            last_out <= 1'b1;
            run <= 16'h0;
        end else begin
            if (take && address == OFF_CTRL_ONE) ctl_one <= writedata[7:0];
            if (take && address == OFF_CTRL_TWO) ctl_two <= writedata[7:0];
            last_out <= serial_out_pin_out;
            run <= (serial_out_pin_out != last_out) ? 16'h1 : run + 16'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_wait_one; $fell(waitrequest) |=> waitrequest; endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    property p_wait_ans; ($rose(read) || $rose(write)) |=> !waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans)
        else $error("request not answered after one wait state");
    property p_rd_hi; read && !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi)
        else $error("read data upper bytes not zero");
    property p_tx_owned; $fell(serial_out_pin_out) |-> serial_out_pin_oe;
    endproperty
    a_tx_owned: assert property (p_tx_owned)
        else $error("line driven low without owning the pin");
    property p_keep_pin; $fell(serial_out_pin_oe) |->
        $past(serial_out_pin_out) && $past(serial_out_pin_out, 8); endproperty
    a_keep_pin: assert property (p_keep_pin)
        else $error("pin released in mid character");
    property p_owned; own_exp == $past(own_exp) && own_exp ==
        $past(own_exp, 2) |-> serial_in_pin_owned == own_exp; endproperty
    a_owned: assert property (p_owned)
        else $error("input pin ownership wrong");
    property p_irq_off; (ctl_two[7:4] == 4'h0) [*3] |-> !irq; endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt with all sources masked");
    property p_bit_time; serial_out_pin_oe && serial_out_pin_out &&
        !last_out |-> run[3:0] == 4'h0; endproperty
    a_bit_time: assert property (p_bit_time)
        else $error("low run not whole bit times");
endmodule : spc_serial_port_monitor
bind spc_serial_port spc_serial_port_monitor u_mon (.clk(clk),
    .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .serial_out_pin_out(serial_out_pin_out), .irq(irq),
    .serial_out_pin_oe(serial_out_pin_oe),
    .serial_in_pin_owned(serial_in_pin_owned));

// File: test/test_serial_port_ctrl_status.sv
// bench for the serial port control and transmit status slice
`timescale 1ns/10ps
`define CHK(a, e) \
    begin \
        comparisons++; \
        if ((a) !== (e)) begin \
            mismatches++; \
            $display("BAD %0t got %0h want %0h", $time, (a), (e)); \
        end \
    end
module test_serial_port_ctrl_status
    import spc_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, pin_out, pin_oe, owned, irq, rxd, wdrv, stp;
    logic [7:0] q, b;
    int mismatches = 0, comparisons = 0, cyc = 0, low = 0, lrun = 0, e;
    wire logic tx_wire = pin_oe ? pin_out : wdrv;
    always #5 clk = ~clk;
    spc_serial_port dut (.clk(clk), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .irq(irq),
        .readdata(readdata), .waitrequest(waitrequest),
        .serial_out_pin_in(tx_wire), .serial_out_pin_out(pin_out),
        .serial_out_pin_oe(pin_oe), .serial_in_pin(rxd),
        .serial_in_pin_owned(owned));
    spc_remote_peer peer (.clk(clk), .tx_line(tx_wire), .rx_line(rxd),
        .wire_drive(wdrv));
    // ------------------------------------------------------------
    // bus tasks, line watch and closing
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic acc(input bit w, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 40);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 40) mismatches++;
    endtask : acc
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] x);
        acc(1'b0, a, 8'h00);
        `CHK(q, x)
    endtask : rd
    // length of the last low run on the wire, and the hang limit
    always @(posedge clk) begin
        cyc++;
        if (tx_wire === 1'b0) low++;
        else if (low != 0) begin
            lrun = low;
            low = 0;
        end
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFF_CTRL_TWO, RST_CTRL);
        rd(OFF_STATUS_ONE, 8'hc0);
        `CHK({irq, pin_oe, owned}, 3'b000)
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CTRL_TWO, 8'h80 >> i);
            rd(OFF_CTRL_TWO, 8'h80 >> i);
            `CHK(irq, (i < 2))
        end
        wr(OFF_CTRL_TWO, 8'h00);
        wr(OFF_STATUS_ONE, 8'h00);
        rd(OFF_STATUS_ONE, 8'hc0);
        $display("reset and enables over");
        wr(OFF_CTRL_TWO, 8'h08);
        rd(OFF_STATUS_ONE, 8'h80);
        `CHK(pin_oe, 1'b1)
        wr(OFF_DATA, 8'ha5);
        rd(OFF_STATUS_ONE, 8'h00);
        wr(OFF_CTRL_TWO, 8'h00);
        peer.grab(b, stp);
        `CHK({b, stp}, 9'h14b)
        repeat (200) @(posedge clk);
        `CHK(pin_oe, 1'b0)
        rd(OFF_STATUS_ONE, 8'hc0);
        $display("transmit over");
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CTRL_AUX, 8'(i));
            wr(OFF_CTRL_TWO, 8'h09);
            wr(OFF_CTRL_TWO, 8'h08);
            repeat (700) @(posedge clk);
            e = int'(BIT_CYCLES * (i ? LONG_BREAK_BITS : BREAK_BITS));
            `CHK(lrun == e || lrun == 2 * e, 1'b1)
            wr(OFF_CTRL_TWO, 8'h00);
        end
        $display("break over");
        wr(OFF_CTRL_AUX, 8'h00);
        wr(OFF_CTRL_TWO, 8'h24);
        repeat (3) @(posedge clk);
        `CHK(owned, 1'b1)
        peer.send(8'h5a, 1'b0);
        repeat (10) @(posedge clk);
        rd(OFF_STATUS_ONE, 8'he0);
        `CHK(irq, 1'b1)
        repeat (200) @(posedge clk);
        rd(OFF_STATUS_ONE, 8'hf0);
        rd(OFF_DATA, 8'h5a);
        rd(OFF_STATUS_ONE, 8'hc0);
        wr(OFF_CTRL_ONE, 8'h80);
        repeat (3) @(posedge clk);
        `CHK(owned, 1'b0)
        wr(OFF_CTRL_ONE, 8'h00);
        wr(OFF_CTRL_TWO, 8'h06);
        peer.send(8'h11, 1'b0);
        repeat (200) @(posedge clk);
        rd(OFF_CTRL_TWO, 8'h04);
        acc(1'b0, OFF_STATUS_ONE, 8'h00);
        acc(1'b0, OFF_DATA, 8'h00);
        wr(OFF_CTRL_ONE, 8'h08);
        wr(OFF_CTRL_TWO, 8'h06);
        peer.send(8'h11, 1'b0);
        peer.send(8'h91, 1'b0);
        repeat (10) @(posedge clk);
        rd(OFF_CTRL_TWO, 8'h04);
        rd(OFF_DATA, 8'h91);
        $display("receive and wakeup over");
        wr(OFF_CTRL_ONE, 8'ha0);
        wr(OFF_CTRL_TWO, 8'h0c);
        repeat (200) @(posedge clk);
        `CHK(pin_oe, 1'b0)
        peer.send(8'hc3, 1'b1);
        repeat (10) @(posedge clk);
        rd(OFF_DATA, 8'hc3);
        wr(OFF_CTRL_AUX, 8'h02);
        repeat (3) @(posedge clk);
        `CHK(pin_oe, 1'b1)
        $display("single wire over");
        end_sim();
    end
endmodule : test_serial_port_ctrl_status
